// ==== adc_params.svh ====
// register offsets, field positions, limits and reset values
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH

`define ADC_ADDR_W       8
`define ADC_DATA_W       32

`define ADC_OFS_CTRL     8'h00
`define ADC_OFS_GAIN     8'h04
`define ADC_OFS_OFFSET   8'h08
`define ADC_OFS_ON_THR   8'h0C
`define ADC_OFS_OFF_THR  8'h10
`define ADC_OFS_DEC      8'h14
`define ADC_OFS_STATUS   8'h18
`define ADC_OFS_ACT_X    8'h1C
`define ADC_OFS_ACT_Y    8'h20
`define ADC_OFS_DIFF     8'h24

`define ADC_CTRL_ON_SEL  0
`define ADC_CTRL_OFF_SEL 1
`define ADC_DEC_MSB      1
`define ADC_STAT_Q       0

`define ADC_RAW_MAX      11'h3E8
`define ADC_GAIN_LIM     32'sh000003E8
`define ADC_GAIN_DIV     32'sh00000064
`define ADC_OFFSET_LIM   32'sh00002710
`define ADC_THR_LIM      32'sh00004E20

`define ADC_GAIN_RST     24'sh000064
`define ADC_VAL_RST      24'sh000000
`define ADC_DEC_RST      2'h0

`endif

// ==== adc_pkg.sv ====
// types shared by the analogue difference comparator
`default_nettype none
package adc_pkg;

   // signed working value; wide enough for every scaled quantity
   typedef logic signed [23:0] adc_val_t;

   typedef struct packed {
      logic        primed;
      logic        on_ref_sel;
      logic        off_ref_sel;
      adc_val_t    gain;
      adc_val_t    offset;
      adc_val_t    on_thr;
      adc_val_t    off_thr;
      logic [1:0]  dec;
      adc_val_t    act_x;
      adc_val_t    act_y;
      adc_val_t    diff;
      logic        q;
      logic [31:0] rd_data;
   } adc_state_s;

endpackage
`default_nettype wire

// ==== adc_comparator.sv ====
// analogue difference comparator with register port
//
// The plain strobed port and the register addresses were chosen for this implementation.
`include "adc_params.svh"
`default_nettype none

// What this block does
// - same gain and offset scale both inputs
// - raw inputs clamp to zero through 1000
// - gain held in hundredths, within plus/minus 10.00
// - offset limited to plus/minus 10000
// - both thresholds limited to plus/minus 20000
// - decimal places take only values 0..3
// - decimal places never affect the comparison
// - hysteresis: set when difference exceeds on
// - hysteresis: clear when difference at most off
// - window: on at or above on, below off
// - thresholds may follow another block's value
// - thresholds and decimals written only in parameter mode
module adc_comparator
   import adc_pkg::*;
(
   input  wire logic                     core_clk,
   input  wire logic                     rst_n,
   input  wire logic [`ADC_ADDR_W-1:0]   addr,
   input  wire logic [`ADC_DATA_W-1:0]   wr_data,
   input  wire logic                     wr_stb,
   input  wire logic                     rd_stb,
   input  wire logic                     param_mode,
   input  wire logic [10:0]              first_analog_in,
   input  wire logic [10:0]              second_analog_in,
   input  wire logic signed [23:0]       on_ref_value,
   input  wire logic signed [23:0]       off_ref_value,
   output logic                          switch_out,
   output logic [`ADC_DATA_W-1:0]        rd_data
);

   ////////////////////////////////////////////////////////////////////////
   // arithmetic helpers

   // saturate a signed word to +/- lim
   function automatic adc_val_t clamp(input logic signed [31:0] v,
                                      input logic signed [31:0] lim);
      logic signed [31:0] r;
      r = v;
      if (v > lim)
         r = lim;
      else if (v < -lim)
         r = -lim;
      return adc_val_t'(r);
   endfunction

   // actual value = raw * gain / 100 + offset, truncated toward zero
   function automatic adc_val_t scale(input logic [10:0] raw,
                                      input adc_val_t    g,
                                      input adc_val_t    o);
      logic [10:0]        rc;
      logic signed [31:0] rx;
      logic signed [31:0] p;
      rc = (raw > `ADC_RAW_MAX) ? `ADC_RAW_MAX : raw;
      rx = signed'({21'h000000, rc});
      p  = (rx * 32'(g)) / `ADC_GAIN_DIV;
      return adc_val_t'(p + 32'(o));
   endfunction

   // largest magnitude an actual value can reach at full scale
   function automatic logic signed [31:0] act_bound();
      return `ADC_GAIN_LIM * signed'(32'(`ADC_RAW_MAX)) / `ADC_GAIN_DIV
             + `ADC_OFFSET_LIM;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // state

   adc_state_s st_reg;
   adc_state_s st_next;
   adc_val_t   on_eff;
   adc_val_t   off_eff;

   assign switch_out = st_reg.q;
   assign rd_data    = st_reg.rd_data;

   // referenced thresholds are sampled every evaluation
   assign on_eff  = st_reg.on_ref_sel
                    ? clamp(32'(on_ref_value), `ADC_THR_LIM)
                    : st_reg.on_thr;
   assign off_eff = st_reg.off_ref_sel
                    ? clamp(32'(off_ref_value), `ADC_THR_LIM)
                    : st_reg.off_thr;

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      st_next         = st_reg;
      st_next.primed  = 1'h1;
      st_next.rd_data = '0;

      if (wr_stb) begin
         case (addr)
            `ADC_OFS_CTRL: begin
               st_next.on_ref_sel  = wr_data[`ADC_CTRL_ON_SEL];
               st_next.off_ref_sel = wr_data[`ADC_CTRL_OFF_SEL];
            end
            `ADC_OFS_GAIN: begin
               st_next.gain = clamp(wr_data, `ADC_GAIN_LIM);
            end
            `ADC_OFS_OFFSET: begin
               st_next.offset = clamp(wr_data, `ADC_OFFSET_LIM);
            end
            `ADC_OFS_ON_THR: begin
               if (param_mode) begin
                  st_next.on_thr = clamp(wr_data, `ADC_THR_LIM);
               end
            end
            `ADC_OFS_OFF_THR: begin
               if (param_mode) begin
                  st_next.off_thr = clamp(wr_data, `ADC_THR_LIM);
               end
            end
            `ADC_OFS_DEC: begin
               if (param_mode) begin
                  st_next.dec = wr_data[`ADC_DEC_MSB:0];
               end
            end
            default: begin
            end
         endcase
      end

      if (rd_stb) begin
         case (addr)
            `ADC_OFS_CTRL: begin
               st_next.rd_data[`ADC_CTRL_ON_SEL]  = st_reg.on_ref_sel;
               st_next.rd_data[`ADC_CTRL_OFF_SEL] = st_reg.off_ref_sel;
            end
            `ADC_OFS_GAIN:    st_next.rd_data = 32'(st_reg.gain);
            `ADC_OFS_OFFSET:  st_next.rd_data = 32'(st_reg.offset);
            `ADC_OFS_ON_THR:  st_next.rd_data = 32'(on_eff);
            `ADC_OFS_OFF_THR: st_next.rd_data = 32'(off_eff);
            `ADC_OFS_DEC: begin
               st_next.rd_data[`ADC_DEC_MSB:0] = st_reg.dec;
            end
            `ADC_OFS_STATUS: begin
               st_next.rd_data[`ADC_STAT_Q] = st_reg.q;
            end
            `ADC_OFS_ACT_X:   st_next.rd_data = 32'(st_reg.act_x);
            `ADC_OFS_ACT_Y:   st_next.rd_data = 32'(st_reg.act_y);
            `ADC_OFS_DIFF:    st_next.rd_data = 32'(st_reg.diff);
            default:          st_next.rd_data = '0;
         endcase
      end

      // pipelined one stage per clock: scale now, subtract a clock later, compare a clock after that
      st_next.act_x = scale(first_analog_in, st_reg.gain,
                            st_reg.offset);
      st_next.act_y = scale(second_analog_in, st_reg.gain,
                            st_reg.offset);
      st_next.diff  = st_reg.act_x - st_reg.act_y;

      // comparison works on raw integers; dec is display only
      if (on_eff >= off_eff) begin
         if (st_reg.diff > on_eff)
            st_next.q = 1'h1;
         else if (st_reg.diff <= off_eff)
            st_next.q = 1'h0;
         else
            st_next.q = st_reg.q;
      end else begin
         st_next.q = (st_reg.diff >= on_eff) &&
                     (st_reg.diff < off_eff);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg.primed      <= 1'h0;
         st_reg.on_ref_sel  <= 1'h0;
         st_reg.off_ref_sel <= 1'h0;
         st_reg.gain        <= `ADC_GAIN_RST;
         st_reg.offset      <= `ADC_VAL_RST;
         st_reg.on_thr      <= `ADC_VAL_RST;
         st_reg.off_thr     <= `ADC_VAL_RST;
         st_reg.dec         <= `ADC_DEC_RST;
         st_reg.act_x       <= `ADC_VAL_RST;
         st_reg.act_y       <= `ADC_VAL_RST;
         st_reg.diff        <= `ADC_VAL_RST;
         st_reg.q           <= 1'h0;
         st_reg.rd_data     <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   chk_gain_shared: assert property (
      st_reg.primed &&
      $past(first_analog_in) == $past(second_analog_in)
      |-> st_reg.act_x == st_reg.act_y)
      else $error("equal inputs gave unequal actual values");

   chk_unity_gain: assert property (
      st_reg.primed && $past(st_reg.gain) == `ADC_GAIN_RST &&
      $past(first_analog_in) <= `ADC_RAW_MAX
      |-> 32'(st_reg.act_x) ==
          32'($past(first_analog_in)) + 32'($past(st_reg.offset)))
      else $error("unity gain did not pass raw value plus offset");

   chk_raw_ceiling: assert property (
      st_reg.primed && $past(second_analog_in) > `ADC_RAW_MAX
      |-> st_reg.act_y == scale(`ADC_RAW_MAX, $past(st_reg.gain),
                                $past(st_reg.offset)))
      else $error("raw value above full scale was not clamped");

   chk_gain_range: assert property (
      32'(st_reg.gain) <= `ADC_GAIN_LIM &&
      32'(st_reg.gain) >= -`ADC_GAIN_LIM)
      else $error("gain outside allowed range");

   chk_offset_range: assert property (
      32'(st_reg.offset) <= `ADC_OFFSET_LIM &&
      32'(st_reg.offset) >= -`ADC_OFFSET_LIM)
      else $error("offset outside allowed range");

   chk_thr_range: assert property (
      32'(on_eff) <= `ADC_THR_LIM && 32'(on_eff) >= -`ADC_THR_LIM &&
      32'(off_eff) <= `ADC_THR_LIM && 32'(off_eff) >= -`ADC_THR_LIM)
      else $error("threshold outside allowed range");

   chk_dec_write: assert property (
      wr_stb && param_mode && addr == `ADC_OFS_DEC
      |=> st_reg.dec == $past(wr_data[`ADC_DEC_MSB:0]))
      else $error("decimal places write not taken");

   chk_set_above: assert property (
      on_eff >= off_eff && st_reg.diff > on_eff |=> st_reg.q)
      else $error("output not set above on threshold");

   chk_clear_below: assert property (
      on_eff >= off_eff && st_reg.diff <= off_eff |=> !st_reg.q)
      else $error("output not cleared at or below off threshold");

   chk_window_test: assert property (
      on_eff < off_eff
      |=> st_reg.q == ($past(st_reg.diff) >= $past(on_eff) &&
                       $past(st_reg.diff) < $past(off_eff)))
      else $error("window output wrong");

   chk_hold_band: assert property (
      on_eff >= off_eff && st_reg.diff > off_eff &&
      st_reg.diff <= on_eff
      |=> st_reg.q == $past(st_reg.q))
      else $error("output changed inside hysteresis band");

   chk_pmode_lock: assert property (
      wr_stb && !param_mode &&
      (addr == `ADC_OFS_ON_THR || addr == `ADC_OFS_OFF_THR ||
       addr == `ADC_OFS_DEC)
      |=> $stable(st_reg.on_thr) && $stable(st_reg.off_thr) &&
          $stable(st_reg.dec))
      else $error("run-time write accepted outside parameter mode");

   chk_diff_wide: assert property (
      st_reg.primed
      |-> 32'(st_reg.diff) ==
          32'($past(st_reg.act_x)) - 32'($past(st_reg.act_y)))
      else $error("difference wrapped or wrong");

   chk_read_slot: assert property (
      !$past(rd_stb) |-> rd_data == '0)
      else $error("read data outside its slot");

   chk_gain_write: assert property (
      wr_stb && addr == `ADC_OFS_GAIN &&
      signed'(wr_data) <= `ADC_GAIN_LIM &&
      signed'(wr_data) >= -`ADC_GAIN_LIM
      |=> 32'(st_reg.gain) == $past(wr_data))
      else $error("in-range gain write not taken");

   chk_offset_write: assert property (
      wr_stb && addr == `ADC_OFS_OFFSET &&
      signed'(wr_data) <= `ADC_OFFSET_LIM &&
      signed'(wr_data) >= -`ADC_OFFSET_LIM
      |=> 32'(st_reg.offset) == $past(wr_data))
      else $error("in-range offset write not taken");

   chk_on_write: assert property (
      wr_stb && param_mode && addr == `ADC_OFS_ON_THR &&
      signed'(wr_data) <= `ADC_THR_LIM &&
      signed'(wr_data) >= -`ADC_THR_LIM
      |=> 32'(st_reg.on_thr) == $past(wr_data))
      else $error("on threshold write in parameter mode lost");

   chk_off_write: assert property (
      wr_stb && param_mode && addr == `ADC_OFS_OFF_THR &&
      signed'(wr_data) <= `ADC_THR_LIM &&
      signed'(wr_data) >= -`ADC_THR_LIM
      |=> 32'(st_reg.off_thr) == $past(wr_data))
      else $error("off threshold write in parameter mode lost");

   chk_ctrl_write: assert property (
      wr_stb && addr == `ADC_OFS_CTRL
      |=> st_reg.on_ref_sel == $past(wr_data[`ADC_CTRL_ON_SEL]) &&
          st_reg.off_ref_sel == $past(wr_data[`ADC_CTRL_OFF_SEL]))
      else $error("reference selection write not taken");

   chk_ref_read: assert property (
      rd_stb && addr == `ADC_OFS_ON_THR && st_reg.on_ref_sel &&
      32'(on_ref_value) <= `ADC_THR_LIM &&
      32'(on_ref_value) >= -`ADC_THR_LIM
      |=> rd_data == 32'($past(on_ref_value)))
      else $error("on threshold does not follow its reference");

   chk_ref_clamp: assert property (
      st_reg.on_ref_sel && 32'(on_ref_value) > `ADC_THR_LIM
      |-> 32'(on_eff) == `ADC_THR_LIM)
      else $error("referenced on threshold not saturated");

   chk_dec_display: assert property (
      $changed(st_reg.dec) && $stable(st_reg.diff) &&
      $stable(on_eff) && $stable(off_eff)
      |=> $stable(st_reg.q))
      else $error("decimal places changed the output");

   chk_act_range: assert property (
      32'(st_reg.act_x) <= act_bound() &&
      32'(st_reg.act_x) >= -act_bound() &&
      32'(st_reg.act_y) <= act_bound() &&
      32'(st_reg.act_y) >= -act_bound())
      else $error("actual value beyond full-scale range");

   chk_diff_range: assert property (
      32'(st_reg.diff) <= act_bound() + act_bound() &&
      32'(st_reg.diff) >= -(act_bound() + act_bound()))
      else $error("difference beyond twice full scale");

endmodule
`default_nettype wire

// ==== adc_src_model.sv ====
// model of the analogue channels and reference blocks feeding the comparator
`default_nettype none
module adc_src_model (
   input  wire logic               core_clk,
   input  wire logic               rst_n,
   input  wire logic [10:0]        x_set,
   input  wire logic [10:0]        y_set,
   input  wire logic signed [23:0] on_set,
   input  wire logic signed [23:0] off_set,
   output logic [10:0]             first_analog_in,
   output logic [10:0]             second_analog_in,
   output logic signed [23:0]      on_ref_value,
   output logic signed [23:0]      off_ref_value
);
   timeunit 1ns;
   timeprecision 1ps;

   // channels and reference blocks refresh once per scan
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         first_analog_in  <= '0;
         second_analog_in <= '0;
         on_ref_value     <= '0;
         off_ref_value    <= '0;
      end else begin
         first_analog_in  <= x_set;
         second_analog_in <= y_set;
         on_ref_value     <= on_set;
         off_ref_value    <= off_set;
      end
   end
endmodule
`default_nettype wire

// ==== adc_comparator_test.sv ====
// self-checking bench for the analogue difference comparator
`include "adc_params.svh"
`default_nettype none
module adc_comparator_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic               core_clk;
   logic               rst_n;
   logic               wr_stb;
   logic               rd_stb;
   logic               param_mode;
   logic [7:0]         addr;
   logic [31:0]        wr_data;
   logic [31:0]        rd_data;
   logic [10:0]        x_set;
   logic [10:0]        y_set;
   logic [10:0]        ax;
   logic [10:0]        ay;
   logic signed [23:0] on_set;
   logic signed [23:0] off_set;
   logic signed [23:0] on_ref;
   logic signed [23:0] off_ref;
   logic               switch_out;
   int                 n_fail;
   int                 cmp_count;

   always #20 core_clk = ~core_clk;

   adc_src_model u_src (.core_clk(core_clk), .rst_n(rst_n), .x_set(x_set),
      .y_set(y_set), .on_set(on_set), .off_set(off_set),
      .first_analog_in(ax), .second_analog_in(ay),
      .on_ref_value(on_ref), .off_ref_value(off_ref));

   adc_comparator u_dut (.core_clk(core_clk), .rst_n(rst_n), .addr(addr),
      .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .param_mode(param_mode), .first_analog_in(ax),
      .second_analog_in(ay), .on_ref_value(on_ref),
      .off_ref_value(off_ref), .switch_out(switch_out), .rd_data(rd_data));

   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      if (n_fail == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      addr    <= a;
      wr_data <= d;
      wr_stb  <= 1'h1;
      @(posedge core_clk);
      wr_stb  <= 1'h0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input string nm);
      @(posedge core_clk);
      addr   <= a;
      rd_stb <= 1'h1;
      @(posedge core_clk);
      rd_stb <= 1'h0;
      @(negedge core_clk);
      chk(nm, e, rd_data);
   endtask

   // set both raw inputs and let the pipeline settle
   task automatic drive(input logic [10:0] x, input logic [10:0] y);
      @(posedge core_clk);
      x_set <= x;
      y_set <= y;
      repeat (6) @(posedge core_clk);
   endtask

   task automatic step(input logic [10:0] x, input logic q);
      drive(x, 11'h000);
      @(negedge core_clk);
      chk("switch_out", {31'h0, q}, {31'h0, switch_out});
      rd(`ADC_OFS_STATUS, {31'h0, q}, "status");
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'h0; rst_n = 1'h0; wr_stb = 1'h0; rd_stb = 1'h0;
      param_mode = 1'h0; addr = 8'h00; wr_data = 32'h0;
      x_set = 11'h000; y_set = 11'h000; on_set = 24'sh0; off_set = 24'sh0;
      n_fail = 0; cmp_count = 0;
      repeat (10) @(posedge core_clk);
      rst_n <= 1'h1;
      rd(`ADC_OFS_CTRL, 32'h0, "ctrl");
      rd(`ADC_OFS_GAIN, 32'h00000064, "gain");
      rd(`ADC_OFS_OFFSET, 32'h0, "offset");
      rd(`ADC_OFS_ON_THR, 32'h0, "on_thr");
      rd(`ADC_OFS_DEC, 32'h0, "dec");
      // gain 2.50, offset -30, first raw value over range
      wr(`ADC_OFS_GAIN, 32'h000000FA);
      wr(`ADC_OFS_OFFSET, 32'hFFFFFFE2);
      drive(11'h7FF, 11'h003);
      rd(`ADC_OFS_ACT_X, 32'h000009A6, "act_x");
      rd(`ADC_OFS_ACT_Y, 32'hFFFFFFE9, "act_y");
      rd(`ADC_OFS_DIFF, 32'h000009BD, "diff");
      // second raw value over range, first one truncated in the divide
      drive(11'h005, 11'h7FF);
      rd(`ADC_OFS_ACT_X, 32'hFFFFFFEE, "act_x");
      rd(`ADC_OFS_ACT_Y, 32'h000009A6, "act_y");
      rd(`ADC_OFS_DIFF, 32'hFFFFF648, "diff");
      // gain -10.00 and offset -10000 at the bottom of their ranges
      wr(`ADC_OFS_GAIN, 32'hFFFFFC18);
      wr(`ADC_OFS_OFFSET, 32'hFFFFD8F0);
      drive(11'h3E8, 11'h001);
      rd(`ADC_OFS_ACT_X, 32'hFFFFB1E0, "act_x");
      rd(`ADC_OFS_DIFF, 32'hFFFFD8FA, "diff");
      wr(`ADC_OFS_GAIN, 32'h00002710);
      rd(`ADC_OFS_GAIN, 32'h000003E8, "gain");
      wr(`ADC_OFS_OFFSET, 32'h00004E20);
      rd(`ADC_OFS_OFFSET, 32'h00002710, "offset");
      @(posedge core_clk);
      param_mode <= 1'h1;
      wr(`ADC_OFS_ON_THR, 32'hFFFF8AD0);
      rd(`ADC_OFS_ON_THR, 32'hFFFFB1E0, "on_thr");
      wr(`ADC_OFS_DEC, 32'h00000007);
      rd(`ADC_OFS_DEC, 32'h00000003, "dec");
      wr(`ADC_OFS_GAIN, 32'h00000064);
      wr(`ADC_OFS_OFFSET, 32'h0);
      wr(`ADC_OFS_ON_THR, 32'h000000C8);
      wr(`ADC_OFS_OFF_THR, 32'h00000064);
      @(posedge core_clk);
      param_mode <= 1'h0;
      wr(`ADC_OFS_ON_THR, 32'h00000999);
      rd(`ADC_OFS_ON_THR, 32'h000000C8, "on_thr");
      wr(`ADC_OFS_DEC, 32'h0);
      rd(`ADC_OFS_DEC, 32'h00000003, "dec");
      wr(`ADC_OFS_OFF_THR, 32'h00000999);
      rd(`ADC_OFS_OFF_THR, 32'h00000064, "off_thr");
      // hysteresis on 200 off 100, three decimals set
      step(11'h0C9, 1'h1);
      step(11'h096, 1'h1);
      step(11'h064, 1'h0);
      step(11'h0C8, 1'h0);
      step(11'h0C9, 1'h1);
      @(posedge core_clk);
      param_mode <= 1'h1;
      wr(`ADC_OFS_OFF_THR, 32'h000000C8);
      rd(`ADC_OFS_OFF_THR, 32'h000000C8, "off_thr");
      step(11'h0C8, 1'h0);
      step(11'h0C9, 1'h1);
      // window on 100 off 200
      wr(`ADC_OFS_ON_THR, 32'h00000064);
      step(11'h063, 1'h0);
      step(11'h064, 1'h1);
      step(11'h0C7, 1'h1);
      step(11'h0C8, 1'h0);
      // thresholds from other blocks: on 150 off 50
      @(posedge core_clk);
      on_set  <= 24'sh000096;
      off_set <= 24'sh000032;
      wr(`ADC_OFS_CTRL, 32'h00000003);
      rd(`ADC_OFS_CTRL, 32'h00000003, "ctrl");
      rd(`ADC_OFS_OFF_THR, 32'h00000032, "off_thr");
      step(11'h032, 1'h0);
      step(11'h097, 1'h1);
      step(11'h064, 1'h1);
      rd(`ADC_OFS_ON_THR, 32'h00000096, "on_thr");
      step(11'h032, 1'h0);
      @(posedge core_clk);
      on_set <= 24'sh007530;
      repeat (3) @(posedge core_clk);
      rd(`ADC_OFS_ON_THR, 32'h00004E20, "on_thr");
      stop_test();
   end
endmodule
`default_nettype wire
